// *** src/dct_channel.sv ***
// DMA channel transfer control with an AXI4-Lite register slave
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`include "dct_map.svh"

module dct_channel
    import dct_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite register slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Peripheral request and power mode
    input wire logic hwReq,
    input wire logic stopMode,
    // Crossbar access
    output dct_mem_req_t memReq,
    input wire dct_mem_rsp_t memRsp,
    // Channel link and interrupt
    output logic linkTrig,
    output logic [4:0] linkChan,
    output logic intReq
);

    dct_state_t state_r;
    dct_state_t state_nxt;
    logic [31:0] unit, srcNext, dstNext, srcLastSum, mlOff, cnt, wv, srcModMask;
    logic hwGate, startGo, stallOn, eqSize, lastBeat, majorEvt, wrHit, rdHit, accOk;

    // Offset add where only the low modulo bits may change
    function automatic logic [31:0] dct_mod_add(input logic [31:0] a, input logic [31:0] off,
                                                input logic [4:0] m);
        logic [31:0] mask;
        mask = (m == 5'h00) ? 32'hFFFF_FFFF : ((32'h0000_0001 << m) - 32'h0000_0001);
        return (a & ~mask) | ((a + off) & mask);
    endfunction : dct_mod_add

    // Register readback
    function automatic logic [31:0] dct_read(input logic [7:0] a, input dct_state_t st);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            `DCT_OFF_SRC_ADDR: v = st.srcAddr;
            `DCT_OFF_DST_ADDR: v = st.dstAddr;
            `DCT_OFF_OFFS: v = {st.dstOff, st.srcOff};
            `DCT_OFF_ATTR:
            begin
                v[`DCT_ATTR_SSIZE +: 2] = st.srcSize;
                v[`DCT_ATTR_DSIZE +: 2] = st.dstSize;
                v[`DCT_ATTR_SOURCE_ADDRESS_MODULO +: 5] = st.srcMod;
                v[`DCT_ATTR_DMOD +: 5] = st.dstMod;
            end
            `DCT_OFF_MINOR_LOOP_BYTE_COUNT: v = (st.fsm != S_IDLE) ? st.nbytesWork : st.nbytesCfg;
            `DCT_OFF_SRC_LAST: v = st.srcLast;
            `DCT_OFF_DST_LAST: v = st.dstLast;
            `DCT_OFF_ITER: v = {st.beginning_major_iteration_count, st.current_major_iteration_count};
            `DCT_OFF_CSR:
            begin
                v[`DCT_CSR_INT_MAJ] = st.intMajEn;
                v[`DCT_CSR_INT_HALF] = st.intHalfEn;
                v[`DCT_CSR_AUTO_STOP] = st.autoStop;
                v[`DCT_CSR_LINK_EN] = st.linkEn;
                v[`DCT_CSR_LINK_CH +: 5] = st.linkCh;
                v[`DCT_CSR_BWC +: 2] = st.bandwidth_stall_control;
            end
            `DCT_OFF_CTRL:
            begin
                v[`DCT_CTRL_HWREQ_EN] = st.hwReqEn;
                v[`DCT_CTRL_ASYNC_EN] = st.asyncEn;
                v[`DCT_CTRL_HALT_ERR] = st.haltOnErr;
                v[`DCT_CTRL_HALT] = st.halt;
                v[`DCT_CTRL_MAP_EN] = st.mapEn;
                v[`DCT_CTRL_INT_ERR] = st.intErrEn;
            end
            `DCT_OFF_STAT:
            begin
                v[`DCT_STAT_ACTIVE] = (st.fsm != S_IDLE);
                v[`DCT_STAT_DONE] = st.doneF;
                v[`DCT_STAT_MAJ] = st.majF;
                v[`DCT_STAT_HALF] = st.halfF;
                v[`DCT_STAT_ERR] = st.errF;
                v[`DCT_STAT_SW_PEND] = st.swPend;
            end
            `DCT_OFF_ERR: v[1:0] = st.errStat;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction : dct_read

    // Derived terms of the transfer sequence
    always_comb
    begin
        unit = 32'h0000_0001 << state_r.srcSize;
        cnt = state_r.mapEn ? {22'h00_0000, state_r.nbytesCfg[`DCT_NB_CNT_W-1:0]} : state_r.nbytesCfg;
        mlOff = {{12{state_r.nbytesCfg[29]}}, state_r.nbytesCfg[29:`DCT_NB_MLOFF]};
        srcNext = dct_mod_add(state_r.srcAddr, {{16{state_r.srcOff[15]}}, state_r.srcOff}, state_r.srcMod);
        dstNext = dct_mod_add(state_r.dstAddr, {{16{state_r.dstOff[15]}}, state_r.dstOff}, state_r.dstMod);
        srcLastSum = state_r.srcAddr + state_r.srcLast;
        srcModMask = (state_r.srcMod == 5'h00) ? 32'hFFFF_FFFF :
                     ((32'h0000_0001 << state_r.srcMod) - 32'h0000_0001);
        hwGate = hwReq && state_r.hwReqEn && (!stopMode || state_r.asyncEn);
        startGo = (state_r.fsm == S_IDLE) && !state_r.halt && (state_r.swPend || hwGate);
        stallOn = state_r.bandwidth_stall_control[1];
        eqSize = (state_r.srcSize == state_r.dstSize);
        lastBeat = (state_r.nbytesWork <= unit);
        accOk = memRsp.ack && !memRsp.err;
        majorEvt = (state_r.fsm == S_WRITE) && accOk && lastBeat && (state_r.current_major_iteration_count <= 16'h0001);
        wrHit = (state_r.awAddr[1:0] == 2'h0) && (state_r.awAddr <= `DCT_OFF_ERR);
        rdHit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= `DCT_OFF_ERR);
        wv = dct_read(state_r.awAddr, state_r);
        for (int i = 0; i < 4; i++)
        begin
            if (state_r.wStrb[i])
            begin
                wv[i*8 +: 8] = state_r.wData[i*8 +: 8];
            end
        end
    end

    // Next state: bus slave first, then hardware so that hardware updates win over register writes
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.linkPulse = 1'b0;
        // Write address and data are taken in either order
        if (s_axi_awvalid && state_r.awready)
        begin
            state_nxt.awHeld = 1'b1;
            state_nxt.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_r.wready)
        begin
            state_nxt.wHeld = 1'b1;
            state_nxt.wData = s_axi_wdata;
            state_nxt.wStrb = s_axi_wstrb;
        end
        if (state_r.bvalid && s_axi_bready)
        begin
            state_nxt.bvalid = 1'b0;
        end
        // Register write once both halves are held
        if (state_r.awHeld && state_r.wHeld && !state_r.bvalid)
        begin
            state_nxt.awHeld = 1'b0;
            state_nxt.wHeld = 1'b0;
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp = wrHit ? `DCT_RESP_OKAY : `DCT_RESP_SLVERR;
            case (state_r.awAddr)
                `DCT_OFF_SRC_ADDR: state_nxt.srcAddr = wv;
                `DCT_OFF_DST_ADDR: state_nxt.dstAddr = wv;
                `DCT_OFF_OFFS: {state_nxt.dstOff, state_nxt.srcOff} = wv;
                `DCT_OFF_ATTR:
                begin
                    state_nxt.srcSize = wv[`DCT_ATTR_SSIZE +: 2];
                    state_nxt.dstSize = wv[`DCT_ATTR_DSIZE +: 2];
                    state_nxt.srcMod = wv[`DCT_ATTR_SOURCE_ADDRESS_MODULO +: 5];
                    state_nxt.dstMod = wv[`DCT_ATTR_DMOD +: 5];
                end
                `DCT_OFF_MINOR_LOOP_BYTE_COUNT: state_nxt.nbytesCfg = wv;
                `DCT_OFF_SRC_LAST: state_nxt.srcLast = wv;
                `DCT_OFF_DST_LAST: state_nxt.dstLast = wv;
                `DCT_OFF_ITER: {state_nxt.beginning_major_iteration_count, state_nxt.current_major_iteration_count} = wv;
                `DCT_OFF_CSR:
                begin
                    state_nxt.swPend = state_r.swPend | wv[`DCT_CSR_START];
                    state_nxt.intMajEn = wv[`DCT_CSR_INT_MAJ];
                    state_nxt.intHalfEn = wv[`DCT_CSR_INT_HALF];
                    state_nxt.autoStop = wv[`DCT_CSR_AUTO_STOP];
                    state_nxt.linkEn = wv[`DCT_CSR_LINK_EN];
                    state_nxt.linkCh = wv[`DCT_CSR_LINK_CH +: 5];
                    state_nxt.bandwidth_stall_control = wv[`DCT_CSR_BWC +: 2];
                end
                `DCT_OFF_CTRL:
                begin
                    state_nxt.hwReqEn = wv[`DCT_CTRL_HWREQ_EN];
                    state_nxt.asyncEn = wv[`DCT_CTRL_ASYNC_EN];
                    state_nxt.haltOnErr = wv[`DCT_CTRL_HALT_ERR];
                    state_nxt.halt = wv[`DCT_CTRL_HALT];
                    state_nxt.mapEn = wv[`DCT_CTRL_MAP_EN];
                    state_nxt.intErrEn = wv[`DCT_CTRL_INT_ERR];
                end
                `DCT_OFF_STAT:
                begin
                    // Write one to clear, selected by mask
                    state_nxt.doneF = state_r.doneF & ~(state_r.wStrb[0] & state_r.wData[`DCT_STAT_DONE]);
                    state_nxt.majF = state_r.majF & ~(state_r.wStrb[0] & state_r.wData[`DCT_STAT_MAJ]);
                    state_nxt.halfF = state_r.halfF & ~(state_r.wStrb[0] & state_r.wData[`DCT_STAT_HALF]);
                    if (state_r.wStrb[0] && state_r.wData[`DCT_STAT_ERR])
                    begin
                        state_nxt.errF = 1'b0;
                        state_nxt.errStat = 2'h0;
                    end
                end
                default: state_nxt.bresp = `DCT_RESP_SLVERR;
            endcase
        end
        // Register read
        if (state_r.rvalid && s_axi_rready)
        begin
            state_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state_r.arready)
        begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rdata = dct_read(s_axi_araddr, state_r);
            state_nxt.rresp = rdHit ? `DCT_RESP_OKAY : `DCT_RESP_SLVERR;
        end
        // Transfer sequencing
        if (memRsp.ack)
        begin
            state_nxt.mem.req = 1'b0;
        end
        case (state_r.fsm)
            S_IDLE:
            begin
                if (startGo)
                begin
                    state_nxt.fsm = S_READ;
                    state_nxt.nbytesWork = cnt;
                    state_nxt.firstAcc = 1'b1;
                    state_nxt.swPend = 1'b0;
                end
            end
            S_READ:
            begin
                if (memRsp.ack && memRsp.err)
                begin
                    state_nxt.fsm = S_IDLE;
                    state_nxt.errStat[0] = 1'b1;
                end
                else if (memRsp.ack)
                begin
                    state_nxt.data = memRsp.rdata;
                    state_nxt.srcAddr = srcNext;
                    state_nxt.firstAcc = 1'b0;
                    state_nxt.nextSt = S_WRITE;
                    state_nxt.fsm = (stallOn && !(eqSize && state_r.firstAcc)) ? S_STALL : S_WRITE;
                end
            end
            S_WRITE:
            begin
                if (memRsp.ack && memRsp.err)
                begin
                    state_nxt.fsm = S_IDLE;
                    state_nxt.errStat[1] = 1'b1;
                end
                else if (memRsp.ack && !lastBeat)
                begin
                    state_nxt.dstAddr = dstNext;
                    state_nxt.nbytesWork = state_r.nbytesWork - unit;
                    state_nxt.nextSt = S_READ;
                    state_nxt.fsm = stallOn ? S_STALL : S_READ;
                end
                else if (memRsp.ack)
                begin
                    // Minor loop done; one activation ends here
                    state_nxt.nbytesWork = 32'h0000_0000;
                    state_nxt.nextSt = S_IDLE;
                    state_nxt.fsm = (stallOn && !eqSize) ? S_STALL : S_IDLE;
                    if (majorEvt)
                    begin
                        state_nxt.doneF = 1'b1;
                        state_nxt.srcAddr = srcLastSum;
                        state_nxt.dstAddr = dstNext + state_r.dstLast;
                        state_nxt.current_major_iteration_count = state_r.beginning_major_iteration_count;
                        state_nxt.majF = 1'b1;
                        state_nxt.linkPulse = state_r.linkEn;
                        if (state_r.autoStop)
                        begin
                            state_nxt.hwReqEn = 1'b0;
                        end
                    end
                    else
                    begin
                        state_nxt.current_major_iteration_count = state_r.current_major_iteration_count - 16'h0001;
                        state_nxt.dstAddr = dstNext;
                        if ((state_r.current_major_iteration_count - 16'h0001) == (state_r.beginning_major_iteration_count >> 1))
                        begin
                            state_nxt.halfF = 1'b1;
                        end
                        // Minor loop offsets under byte count mapping
                        if (state_r.mapEn && state_r.nbytesCfg[`DCT_NB_SMLOE])
                        begin
                            state_nxt.srcAddr = state_r.srcAddr + mlOff;
                        end
                        if (state_r.mapEn && state_r.nbytesCfg[`DCT_NB_DMLOE])
                        begin
                            state_nxt.dstAddr = dstNext + mlOff;
                        end
                    end
                end
            end
            S_STALL:
            begin
                state_nxt.stallCnt = state_r.stallCnt - 4'h1;
                if (state_r.stallCnt == 4'h1)
                begin
                    state_nxt.fsm = state_r.nextSt;
                end
            end
            default: state_nxt.fsm = S_IDLE;
        endcase
        // Error flag and halt on error
        if (memRsp.ack && memRsp.err && (state_r.fsm == S_READ || state_r.fsm == S_WRITE))
        begin
            state_nxt.errF = 1'b1;
            state_nxt.halt = state_nxt.halt | state_r.haltOnErr;
        end
        // Stall length and bus access on entry to a state
        if (state_nxt.fsm == S_STALL && state_r.fsm != S_STALL)
        begin
            state_nxt.stallCnt = state_r.bandwidth_stall_control[0] ? `DCT_BWC_STALL_HI : `DCT_BWC_STALL_LO;
        end
        if (state_nxt.fsm == S_READ && state_r.fsm != S_READ)
        begin
            state_nxt.mem = {1'b1, 1'b0, state_r.srcSize, state_nxt.srcAddr, 32'h0000_0000};
        end
        if (state_nxt.fsm == S_WRITE && state_r.fsm != S_WRITE)
        begin
            state_nxt.mem = {1'b1, 1'b1, state_r.dstSize, state_nxt.dstAddr, state_nxt.data};
        end
        // Masked interrupt sources and bus handshakes
        state_nxt.intReq = (state_nxt.majF & state_nxt.intMajEn) | (state_nxt.halfF & state_nxt.intHalfEn) |
                           (state_nxt.errF & state_nxt.intErrEn);
        state_nxt.awready = !state_nxt.awHeld && !state_nxt.bvalid;
        state_nxt.wready = !state_nxt.wHeld && !state_nxt.bvalid;
        state_nxt.arready = !state_nxt.rvalid;
    end

    // State register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= '0;
            state_r.fsm <= S_IDLE;
            state_r.nextSt <= S_IDLE;
            state_r.current_major_iteration_count <= `DCT_RST_ITER;
            state_r.beginning_major_iteration_count <= `DCT_RST_ITER;
            state_r.awready <= 1'b1;
            state_r.wready <= 1'b1;
            state_r.arready <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = state_r.awready;
    assign s_axi_wready = state_r.wready;
    assign s_axi_bvalid = state_r.bvalid;
    assign s_axi_bresp = state_r.bresp;
    assign s_axi_arready = state_r.arready;
    assign s_axi_rvalid = state_r.rvalid;
    assign s_axi_rdata = state_r.rdata;
    assign s_axi_rresp = state_r.rresp;
    assign memReq = state_r.mem;
    assign linkTrig = state_r.linkPulse;
    assign linkChan = state_r.linkCh;
    assign intReq = state_r.intReq;

    // Checks of the transfer sequence
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    minor_seq_a: assert property ((state_r.fsm == S_READ) && accOk |=> (state_r.fsm == S_WRITE) || (state_r.fsm == S_STALL))
        else $error("read not followed by write");
    bwc_stall_a: assert property ($rose(state_r.fsm == S_STALL) && (state_r.bandwidth_stall_control == 2'h3) |->
        (state_r.fsm == S_STALL)[*8] ##1 (state_r.fsm != S_STALL))
        else $error("stall length wrong");
    size_skip_a: assert property ((state_r.fsm == S_READ) && accOk && state_r.firstAcc && eqSize |=> state_r.fsm == S_WRITE)
        else $error("first stall not skipped");
    src_wrap_a: assert property ((state_r.fsm == S_READ) && accOk && (state_r.srcMod != 5'h00) |=>
        ((state_r.srcAddr ^ $past(state_r.srcAddr)) & ~srcModMask) == 32'h0000_0000)
        else $error("frozen source bits changed");
    stop_gate_a: assert property ((state_r.fsm == S_IDLE) && stopMode && !state_r.asyncEn && !state_r.swPend |=>
        state_r.fsm == S_IDLE)
        else $error("request taken in stop mode");
    auto_stop_a: assert property (majorEvt && state_r.autoStop |=> !state_r.hwReqEn)
        else $error("request enable not cleared");
    last_adj_a: assert property (majorEvt |=> state_r.srcAddr == $past(srcLastSum))
        else $error("source last adjustment missing");
    sw_once_a: assert property (startGo && !hwGate |=> ##[1:1000] (state_r.fsm == S_IDLE))
        else $error("software start did not end");
    halt_ign_a: assert property ((state_r.fsm == S_IDLE) && state_r.halt |=> state_r.fsm == S_IDLE)
        else $error("request served while halted");
    link_trig_a: assert property (majorEvt && state_r.linkEn |=> linkTrig ##1 !linkTrig)
        else $error("major link not pulsed");
    iter_reload_a: assert property (majorEvt |=> state_r.current_major_iteration_count == $past(state_r.beginning_major_iteration_count) && state_r.majF)
        else $error("iteration count not reloaded");
    no_stall_a: assert property (!state_r.bandwidth_stall_control[1] && (state_r.fsm != S_STALL) |=> state_r.fsm != S_STALL)
        else $error("stall without bandwidth setting");

endmodule : dct_channel

// *** src/dct_map.svh ***
// Register offsets, field positions, reset values and timing counts of the DMA channel
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH
// Register byte offsets
`define DCT_OFF_SRC_ADDR 8'h00
`define DCT_OFF_DST_ADDR 8'h04
`define DCT_OFF_OFFS 8'h08
`define DCT_OFF_ATTR 8'h0C
`define DCT_OFF_MINOR_LOOP_BYTE_COUNT 8'h10
`define DCT_OFF_SRC_LAST 8'h14
`define DCT_OFF_DST_LAST 8'h18
`define DCT_OFF_ITER 8'h1C
`define DCT_OFF_CSR 8'h20
`define DCT_OFF_CTRL 8'h24
`define DCT_OFF_STAT 8'h28
`define DCT_OFF_ERR 8'h2C
// Attribute fields (lsb positions)
`define DCT_ATTR_SSIZE 0
`define DCT_ATTR_DSIZE 4
`define DCT_ATTR_SOURCE_ADDRESS_MODULO 8
`define DCT_ATTR_DMOD 16
// Channel control and status fields
`define DCT_CSR_START 0
`define DCT_CSR_INT_MAJ 1
`define DCT_CSR_INT_HALF 2
`define DCT_CSR_AUTO_STOP 3
`define DCT_CSR_LINK_EN 5
`define DCT_CSR_LINK_CH 8
`define DCT_CSR_BWC 14
// Engine control fields
`define DCT_CTRL_HWREQ_EN 0
`define DCT_CTRL_ASYNC_EN 1
`define DCT_CTRL_HALT_ERR 2
`define DCT_CTRL_HALT 3
`define DCT_CTRL_MAP_EN 4
`define DCT_CTRL_INT_ERR 5
// Status fields
`define DCT_STAT_ACTIVE 0
`define DCT_STAT_DONE 1
`define DCT_STAT_MAJ 2
`define DCT_STAT_HALF 3
`define DCT_STAT_ERR 4
`define DCT_STAT_SW_PEND 5
// Byte count word layout with minor loop mapping
`define DCT_NB_SMLOE 31
`define DCT_NB_DMLOE 30
`define DCT_NB_MLOFF 10
`define DCT_NB_CNT_W 10
// Stall cycles per bandwidth setting, reset value, bus answers
`define DCT_BWC_STALL_LO 4'h4
`define DCT_BWC_STALL_HI 4'h8
`define DCT_RST_ITER 16'h0001
`define DCT_RESP_OKAY 2'h0
`define DCT_RESP_SLVERR 2'h2
`endif

// *** src/dct_pkg.sv ***
// Types of the DMA channel transfer control
package dct_pkg;
    typedef enum logic [2:0] {S_IDLE, S_READ, S_WRITE, S_STALL} dct_fsm_t;
    // Access toward the crossbar
    typedef struct packed {
        logic req;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dct_mem_req_t;
    // Answer from the crossbar
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } dct_mem_rsp_t;
    // Whole state of the channel
    typedef struct packed {
        dct_fsm_t fsm;
        dct_fsm_t nextSt;
        logic [3:0] stallCnt;
        logic firstAcc;
        logic [31:0] data;
        logic [31:0] srcAddr, dstAddr, srcLast, dstLast, nbytesCfg, nbytesWork;
        logic [15:0] srcOff, dstOff, current_major_iteration_count, beginning_major_iteration_count;
        logic [1:0] srcSize, dstSize, bandwidth_stall_control, errStat;
        logic [4:0] srcMod, dstMod, linkCh;
        logic autoStop, linkEn, intMajEn, intHalfEn, intErrEn;
        logic hwReqEn, asyncEn, haltOnErr, halt, mapEn, swPend;
        logic doneF, majF, halfF, errF, linkPulse, intReq;
        dct_mem_req_t mem;
        logic awready, wready, arready, awHeld, wHeld, bvalid, rvalid;
        logic [7:0] awAddr;
        logic [31:0] wData, rdata;
        logic [3:0] wStrb;
        logic [1:0] bresp, rresp;
    } dct_state_t;
endpackage : dct_pkg

// *** verif/dct_xbar_model.sv ***
// Crossbar stand-in answering each channel access after two wait cycles
`timescale 1ns/1ns
module dct_xbar_model
    import dct_pkg::*;
(
    // Clock and access
    input wire logic clk,
    input wire dct_mem_req_t memReq,
    input wire logic errOn,
    output dct_mem_rsp_t memRsp,
    // Last write taken
    output logic [31:0] lastWrAddr,
    output logic [31:0] lastWrData
);
    logic [1:0] waitCnt = 2'h0;
    initial memRsp = '0;
    // Slow answer; data toggles while no ack stands
    always @(posedge clk)
    begin
        memRsp.ack <= 1'b0;
        memRsp.rdata <= ~memRsp.rdata;
        waitCnt <= (memReq.req && !memRsp.ack) ? waitCnt + 2'h1 : 2'h0;
        if (memReq.req && !memRsp.ack && waitCnt == 2'h2)
        begin
            memRsp.ack <= 1'b1;
            memRsp.rdata <= memReq.addr ^ 32'h5A5A_0000;
            memRsp.err <= errOn;
            if (memReq.write)
                {lastWrAddr, lastWrData} <= {memReq.addr, memReq.wdata};
        end
    end
endmodule : dct_xbar_model

// *** verif/testbench.sv ***
// Self-checking bench of the DMA channel
`timescale 1ns/1ns
module testbench;
    import dct_pkg::*;
    logic clk = 0, reset_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, hr = 0, sm = 0, eo = 0;
    logic [7:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, d, lwa, lwd, rd;
    logic [1:0] r, br, rr;
    logic awr, wr, bv, arr, rv, irq, lt;
    logic [4:0] lc;
    dct_mem_req_t mq;
    dct_mem_rsp_t ms;
    int miscompares = 0, num_checks = 0, n, lk = 0;
    // Address, write data, read back, write answer
    logic [73:0] rows [5] = '{{8'h08, 32'h0004_0004, 32'h0004_0004, 2'h0},
        {8'h0C, 32'h0000_0022, 32'h0000_0022, 2'h0}, {8'h18, 32'hFFFF_FFF0, 32'hFFFF_FFF0, 2'h0},
        {8'h30, 32'h1234_5678, 32'h0000_0000, 2'h2}, {8'h2C, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2}};
    dct_channel dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ar), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .hwReq(hr), .stopMode(sm), .memReq(mq), .memRsp(ms), .linkTrig(lt), .linkChan(lc), .intReq(irq));
    dct_xbar_model xbar (.clk(clk), .memReq(mq), .errOn(eo), .memRsp(ms), .lastWrAddr(lwa), .lastWrData(lwd));
    initial forever #4 clk = ~clk;
    // Link pulses counted
    always @(posedge clk)
    begin
        if (lt === 1'b1)
            lk <= lk + 1;
    end
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    task check(input logic [31:0] s, e);
        num_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, s, e);
        end
    endtask : check
    task wt;
        n++;
        if (n > 300)
        begin
            miscompares++;
            finish_test();
        end
    endtask : wt
    task axw(input logic [7:0] a, input logic [31:0] q, output logic [1:0] s);
        @(posedge clk);
        {aw, wd, awv, wv, bry} <= {a, q, 3'b111};
        n = 0;
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            wt();
        end while (bv !== 1'b1);
        s = br;
        bry <= 1'b0;
    endtask : axw
    task axr(input logic [7:0] a, output logic [31:0] q, output logic [1:0] s);
        @(posedge clk);
        {ar, arv, rry} <= {a, 2'b11};
        n = 0;
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            wt();
        end while (rv !== 1'b1);
        {q, s} = {rd, rr};
        rry <= 1'b0;
    endtask : axr
    task poll(input logic e);
        d = 32'h0000_0001;
        for (int k = 0; k < 60 && (d[0] | d[5]) !== 1'b0; k++) axr(8'h28, d, r);
        check(d[0], 1'b0);
        check(d[1], e);
    endtask : poll
    initial
    begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        axr(8'h1C, d, r);
        check(d, 32'h0001_0001);
        foreach (rows[i])
        begin
            axw(rows[i][73:66], rows[i][65:34], r);
            check(r, rows[i][1:0]);
            axr(rows[i][73:66], d, r);
            check(d, rows[i][33:2]);
        end
        axw(8'h00, 32'h0000_0100, r);
        axw(8'h04, 32'h0000_0200, r);
        axw(8'h10, 32'h0000_0008, r);
        axw(8'h14, 32'hFFFF_FFF0, r);
        axw(8'h1C, 32'h0002_0002, r);
        axw(8'h24, 32'h0000_0001, r);
        axw(8'h20, 32'h0000_C00B, r);
        poll(1'b0);
        check(lwa, 32'h0000_0204);
        check(lwd, 32'h5A5A_0104);
        axr(8'h1C, d, r);
        check(d, 32'h0002_0001);
        axw(8'h28, 32'h0000_0002, r);
        axw(8'h20, 32'h0000_C00B, r);
        poll(1'b1);
        axr(8'h00, d, r);
        check(d, 32'h0000_0100);
        axr(8'h1C, d, r);
        check(d, 32'h0002_0002);
        axr(8'h24, d, r);
        check(d, 32'h0000_0000);
        check(irq, 1'b1);
        // Flags cleared by mask, then hardware requests in stop mode
        axw(8'h28, 32'h0000_001E, r);
        check(irq, 1'b0);
        sm <= 1'b1;
        hr <= 1'b1;
        axw(8'h0C, 32'h0000_0322, r);
        axw(8'h20, 32'h0000_C32A, r);
        axw(8'h24, 32'h0000_0001, r);
        repeat (20) @(posedge clk);
        axr(8'h28, d, r);
        check(d[0], 1'b0);
        axw(8'h24, 32'h0000_0003, r);
        repeat (300) @(posedge clk);
        hr <= 1'b0;
        sm <= 1'b0;
        axr(8'h24, d, r);
        check(d, 32'h0000_0002);
        axr(8'h00, d, r);
        check(d, 32'h0000_00F0);
        check(lwa, 32'h0000_020C);
        check(lk, 1);
        check(lc, 5'h03);
        check(irq, 1'b1);
        // Bus error halts the engine; a later start stays pending
        eo <= 1'b1;
        axw(8'h24, 32'h0000_0004, r);
        axw(8'h20, 32'h0000_0001, r);
        repeat (20) @(posedge clk);
        axr(8'h2C, d, r);
        check(d, 32'h0000_0001);
        axr(8'h24, d, r);
        check(d, 32'h0000_000C);
        eo <= 1'b0;
        axw(8'h20, 32'h0000_0001, r);
        repeat (20) @(posedge clk);
        axr(8'h28, d, r);
        check(d, 32'h0000_003E);
        finish_test();
    end
endmodule : testbench
